// *** include/strap_pkg.sv ***
// shared constants for the supervisor trap register block
// assumes a 64-bit supervisor word and a 32-bit apb register bus
package strap_pkg;
    localparam int supervisor_word_width = 64;
    localparam int max_instruction_length = 32;
    // apb byte offsets, 64-bit registers take a low and a high word
    localparam logic [7:0] off_counter_user_enable = 8'h00;
    localparam logic [7:0] off_scratch_lo = 8'h04;
    localparam logic [7:0] off_scratch_hi = 8'h08;
    localparam logic [7:0] off_return_pc_lo = 8'h0C;
    localparam logic [7:0] off_return_pc_hi = 8'h10;
    localparam logic [7:0] off_cause_lo = 8'h14;
    localparam logic [7:0] off_cause_hi = 8'h18;
    localparam logic [7:0] off_value_lo = 8'h1C;
    localparam logic [7:0] off_value_hi = 8'h20;
    localparam logic [7:0] off_control = 8'h24;
    // field positions
    localparam int control_align32_bit = 0;
    localparam int control_insn_bits_bit = 1;
    localparam int cause_interrupt_bit = 63;
    localparam int cause_code_width = 6;
    // reset values
    localparam logic [31:0] reset_counter_enable = 32'h0000_0000;
    localparam logic [63:0] reset_word = 64'h0000_0000_0000_0000;
    localparam logic [1:0] reset_control = 2'h0;
    // counters that can be enabled; cleared bits are hardwired to zero
    localparam logic [31:0] counter_implemented = 32'hFFFF_FFFF;
    // exception codes
    localparam logic [5:0] exc_fetch_misaligned = 6'h00;
    localparam logic [5:0] exc_fetch_fault = 6'h01;
    localparam logic [5:0] exc_illegal = 6'h02;
    localparam logic [5:0] exc_breakpoint = 6'h03;
    localparam logic [5:0] exc_load_misaligned = 6'h04;
    localparam logic [5:0] exc_load_fault = 6'h05;
    localparam logic [5:0] exc_store_misaligned = 6'h06;
    localparam logic [5:0] exc_store_fault = 6'h07;
    localparam logic [5:0] exc_user_call = 6'h08;
    localparam logic [5:0] exc_super_call = 6'h09;
    localparam logic [5:0] exc_fetch_page = 6'h0C;
    localparam logic [5:0] exc_load_page = 6'h0D;
    localparam logic [5:0] exc_store_page = 6'h0F;
    // interrupt codes
    localparam logic [5:0] irq_software = 6'h01;
    localparam logic [5:0] irq_timer = 6'h05;
    localparam logic [5:0] irq_external = 6'h09;
endpackage

// *** rtl/supervisor_trap_csrs.sv ***
// supervisor trap and counter access registers for one hart
// assumes the core presents trap entry as a one-cycle strobe on core_clk,
// and software reaches the registers over apb on the same clock
//
// Functional notes
// - counter-enable is 32 bits: cycle, time, retired, performance counters.
// - user read of a counter with clear enable bit raises illegal instruction.
// - counter-enable always exists; any bit may be hardwired zero.
// - user access needs both supervisor and machine enable bits set.
// - scratch register stores software writes, no hardware side effects.
// - return pc bit 0 reads zero; bits 1:0 zero if only 32-bit alignment.
// - with 32-bit alignment selected, return pc bit 1 masked on read, still writable.
// - return pc holds every valid virtual address.
// - trap entry loads return pc with faulting instruction address; else software only.
// - trap entry writes cause with interrupt flag and code; else software only.
// - cause code holds at least values 0 to 31.
// - interrupt codes: 1 software, 5 timer, 9 external.
// - exception codes 0-9, 12, 13, 15 as listed for each fault.
// - custom and reserved exception codes are stored as given.
// - trap entry writes trap value; else software only.
// - address faults and breakpoints load faulting address; undefined cases load zero.
// - trap value carries faulting portion address; return pc keeps instruction start.
// - without instruction-bits option, illegal instruction loads zero.
// - with option, instruction bits right-justified, upper bits zero.
// - trap value holds all addresses, zero and instruction values.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module supervisor_trap_csrs (
    input wire logic core_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // trap entry from the core
    input wire logic trap_take,
    input wire logic trap_is_interrupt,
    input wire logic [5:0] trap_code,
    input wire logic [63:0] trap_pc,
    input wire logic [63:0] trap_fault_addr,
    input wire logic [31:0] trap_insn,
    input wire logic [1:0] trap_insn_len,
    // counter read check from the core
    input wire logic user_mode,
    input wire logic counter_read,
    input wire logic [4:0] counter_index,
    input wire logic [31:0] machine_counter_enable,
    output logic counter_illegal,
    // implicit read for supervisor return
    output logic [63:0] supervisor_return_pc,
    output logic instruction_alignment
);

    ////////////////////////////////////////////////////////////////
    // state

    logic [31:0] counter_user_enable;
    logic [63:0] supervisor_scratch;
    logic [63:0] trap_return_pc;
    logic [63:0] trap_cause;
    logic [63:0] trap_value;
    logic [1:0] control;
    logic bus_write;
    logic [31:0] next_trap_value_low;
    logic [63:0] next_trap_value;
    logic [63:0] merged_enable;

    // merge a 32-bit apb write into one half of a 64-bit register
    function automatic logic [63:0] merge_half(input logic [63:0] old, input logic hi,
                                               input logic [31:0] data, input logic [3:0] strb);
        logic [63:0] result;
        result = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                if (hi) begin
                    result[32 + 8 * i +: 8] = data[8 * i +: 8];
                end else begin
                    result[8 * i +: 8] = data[8 * i +: 8];
                end
            end
        end
        return result;
    endfunction

    // apb always answers in the access cycle, no wait states
    assign pready = 1'b1;
    assign bus_write = psel && penable && pwrite;
    assign instruction_alignment = control[strap_pkg::control_align32_bit];
    // counter enable rides in the low half of the merge, upper half is discarded
    assign merged_enable = merge_half({32'h0000_0000, counter_user_enable}, 1'b0, pwdata, pstrb);

    ////////////////////////////////////////////////////////////////
    // counter access check

    // hardwired-zero bits keep their zero whatever is written
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_user_enable <= strap_pkg::reset_counter_enable;
        end else if (bus_write && paddr == strap_pkg::off_counter_user_enable) begin
            counter_user_enable <= merged_enable[31:0] & strap_pkg::counter_implemented;
        end
    end

    // machine enable gates the check only, never the writability above
    assign counter_illegal = user_mode && counter_read &&
        !(counter_user_enable[counter_index] && machine_counter_enable[counter_index]);

    ////////////////////////////////////////////////////////////////
    // scratch and control

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            supervisor_scratch <= strap_pkg::reset_word;
        end else if (bus_write && (paddr == strap_pkg::off_scratch_lo || paddr == strap_pkg::off_scratch_hi)) begin
            supervisor_scratch <= merge_half(supervisor_scratch, paddr == strap_pkg::off_scratch_hi,
                                             pwdata, pstrb);
        end
    end

    // bit 0 selects 32-bit alignment, bit 1 enables instruction bits in trap value
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            control <= strap_pkg::reset_control;
        end else if (bus_write && paddr == strap_pkg::off_control && pstrb[0]) begin
            control <= pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // trap entry registers; trap entry beats a software write in the same cycle

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_return_pc <= strap_pkg::reset_word;
        end else if (trap_take) begin
            trap_return_pc <= {trap_pc[63:1], 1'b0};
        end else if (bus_write && (paddr == strap_pkg::off_return_pc_lo || paddr == strap_pkg::off_return_pc_hi)) begin
            // bit 1 stays writable even while it reads masked
            trap_return_pc <= merge_half(trap_return_pc, paddr == strap_pkg::off_return_pc_hi,
                                         pwdata, pstrb) & ~64'h0000_0000_0000_0001;
        end
    end

    // masked read also feeds the implicit read by supervisor return
    assign supervisor_return_pc = {trap_return_pc[63:2],
                                   trap_return_pc[1] & ~instruction_alignment, 1'b0};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_cause <= strap_pkg::reset_word;
        end else if (trap_take) begin
            // codes stored as given, reserved and custom alike
            trap_cause <= {trap_is_interrupt, 57'h0, trap_code};
        end else if (bus_write && (paddr == strap_pkg::off_cause_lo || paddr == strap_pkg::off_cause_hi)) begin
            // only the flag and a six-bit code exist; other bits read zero
            trap_cause <= merge_half(trap_cause, paddr == strap_pkg::off_cause_hi, pwdata, pstrb)
                          & 64'h8000_0000_0000_003F;
        end
    end

    // instruction bits, right-justified to the length the core reports
    always_comb begin
        case (trap_insn_len)
            2'h1: next_trap_value_low = {16'h0000, trap_insn[15:0]};
            2'h2: next_trap_value_low = trap_insn;
            default: next_trap_value_low = 32'h0000_0000;
        endcase
    end

    // trap value selection by exception kind
    always_comb begin
        next_trap_value = strap_pkg::reset_word;
        if (!trap_is_interrupt) begin
            case (trap_code)
                strap_pkg::exc_fetch_misaligned, strap_pkg::exc_fetch_fault, strap_pkg::exc_breakpoint,
                strap_pkg::exc_load_misaligned, strap_pkg::exc_load_fault, strap_pkg::exc_store_misaligned,
                strap_pkg::exc_store_fault, strap_pkg::exc_fetch_page, strap_pkg::exc_load_page,
                strap_pkg::exc_store_page: begin
                    next_trap_value = trap_fault_addr;
                end
                strap_pkg::exc_illegal: begin
                    if (control[strap_pkg::control_insn_bits_bit]) begin
                        next_trap_value = {32'h0000_0000, next_trap_value_low};
                    end else begin
                        next_trap_value = strap_pkg::reset_word;
                    end
                end
                default: begin
                    next_trap_value = strap_pkg::reset_word;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_value <= strap_pkg::reset_word;
        end else if (trap_take) begin
            trap_value <= next_trap_value;
        end else if (bus_write && (paddr == strap_pkg::off_value_lo || paddr == strap_pkg::off_value_hi)) begin
            trap_value <= merge_half(trap_value, paddr == strap_pkg::off_value_hi, pwdata, pstrb);
        end
    end

    ////////////////////////////////////////////////////////////////
    // apb read mux and error

    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (psel && penable && !pwrite) begin
            case (paddr)
                strap_pkg::off_counter_user_enable: prdata = counter_user_enable;
                strap_pkg::off_scratch_lo: prdata = supervisor_scratch[31:0];
                strap_pkg::off_scratch_hi: prdata = supervisor_scratch[63:32];
                strap_pkg::off_return_pc_lo: prdata = supervisor_return_pc[31:0];
                strap_pkg::off_return_pc_hi: prdata = supervisor_return_pc[63:32];
                strap_pkg::off_cause_lo: prdata = trap_cause[31:0];
                strap_pkg::off_cause_hi: prdata = trap_cause[63:32];
                strap_pkg::off_value_lo: prdata = trap_value[31:0];
                strap_pkg::off_value_hi: prdata = trap_value[63:32];
                strap_pkg::off_control: prdata = {30'h0000_0000, control};
                default: pslverr = 1'b1;
            endcase
        end else if (psel && penable) begin
            case (paddr)
                strap_pkg::off_counter_user_enable, strap_pkg::off_scratch_lo, strap_pkg::off_scratch_hi,
                strap_pkg::off_return_pc_lo, strap_pkg::off_return_pc_hi, strap_pkg::off_cause_lo,
                strap_pkg::off_cause_hi, strap_pkg::off_value_lo, strap_pkg::off_value_hi,
                strap_pkg::off_control: pslverr = 1'b0;
                default: pslverr = 1'b1;
            endcase
        end
    end

endmodule

// *** testbench/trap_csrs_checker.sv ***
// assertion checker for the supervisor trap register block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/100ps
module trap_csrs_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic trap_take,
    input wire logic [63:0] trap_pc,
    input wire logic user_mode,
    input wire logic counter_read,
    input wire logic [4:0] counter_index,
    input wire logic [31:0] machine_counter_enable,
    input wire logic counter_illegal,
    input wire logic [63:0] supervisor_return_pc,
    input wire logic instruction_alignment
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // a software write is the only other way the return pc may move
    wire acc = psel && penable;
    wire sw_wr = acc && pwrite;
    ////////////////////////////////////////
    property p_bit0; supervisor_return_pc[0] == 1'b0; endproperty
    a_bit0: assert property (p_bit0) else $error("return pc bit 0 set");
    property p_bit1; instruction_alignment |-> !supervisor_return_pc[1]; endproperty
    a_bit1: assert property (p_bit1) else $error("return pc bit 1 not masked");
    property p_pc_load; trap_take |=> (supervisor_return_pc >> 2) == ($past(trap_pc) >> 2); endproperty
    a_pc_load: assert property (p_pc_load) else $error("trap did not load return pc");
    property p_pc_hold;
        !trap_take && !sw_wr |=> (supervisor_return_pc >> 2) == ($past(supervisor_return_pc) >> 2);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("return pc moved on its own");
    property p_user_only; counter_illegal |-> user_mode && counter_read; endproperty
    a_user_only: assert property (p_user_only) else $error("counter fault outside user read");
    property p_machine_gate;
        user_mode && counter_read && !machine_counter_enable[counter_index] |-> counter_illegal;
    endproperty
    a_machine_gate: assert property (p_machine_gate) else $error("machine gate ignored");
    property p_cause_lo; acc && !pwrite && paddr == strap_pkg::off_cause_lo |-> prdata[31:6] == 26'h0; endproperty
    a_cause_lo: assert property (p_cause_lo) else $error("cause code too wide");
    property p_cause_hi; acc && !pwrite && paddr == strap_pkg::off_cause_hi |-> prdata[30:0] == 31'h0; endproperty
    a_cause_hi: assert property (p_cause_hi) else $error("cause upper bits set");
    c_trap: cover property (trap_take);
    c_illegal: cover property (counter_illegal);
    c_err: cover property (acc && pslverr);
    c_align: cover property (instruction_alignment && trap_take);
endmodule

// *** testbench/core_trap_model.sv ***
// core side model: issues one-cycle trap entry strobes with their fields
// assumes core_clk is the block's clock
`timescale 1ns/100ps
module core_trap_model (
    input wire logic core_clk,
    output logic trap_take,
    output logic trap_is_interrupt,
    output logic [5:0] trap_code,
    output logic [63:0] trap_pc,
    output logic [63:0] trap_fault_addr,
    output logic [31:0] trap_insn,
    output logic [1:0] trap_insn_len
);
    initial {trap_take, trap_is_interrupt, trap_code, trap_pc, trap_fault_addr, trap_insn, trap_insn_len} = '0;
    // fields are inverted after the strobe so a stale capture cannot pass
    task fire(input logic i, input logic [5:0] c, input logic [63:0] p, input logic [63:0] f,
              input logic [31:0] s, input logic [1:0] l);
        @(posedge core_clk);
        {trap_take, trap_is_interrupt, trap_code, trap_pc} <= {1'b1, i, c, p};
        {trap_fault_addr, trap_insn, trap_insn_len} <= {f, s, l};
        @(posedge core_clk);
        {trap_take, trap_is_interrupt, trap_code, trap_pc} <= {1'b0, ~i, ~c, ~p};
        {trap_fault_addr, trap_insn, trap_insn_len} <= {~f, ~s, ~l};
    endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the supervisor trap register block
// assumes zero-wait apb and the core model for trap strobes
`timescale 1ns/100ps
module testbench;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic trap_take, trap_is_interrupt, user_mode, counter_read, counter_illegal, instruction_alignment;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, machine_counter_enable, trap_insn, r, d, sen, ins;
    logic [3:0] pstrb;
    logic [5:0] trap_code;
    logic [63:0] trap_pc, trap_fault_addr, supervisor_return_pc, v, pc, fa;
    logic [1:0] trap_insn_len, ln;
    logic [4:0] counter_index;
    logic [6:0] tab [19] = '{7'h41, 7'h45, 7'h49, 7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06,
                             7'h07, 7'h08, 7'h09, 7'h0C, 7'h0D, 7'h0F, 7'h18, 7'h30, 7'h0A};
    logic [31:0] msk [9] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFE, 32'hFFFFFFFF,
                             32'h0000003F, 32'h80000000, 32'hFFFFFFFF, 32'hFFFFFFFF};
    int failures = 0;
    int compares = 0;
    supervisor_trap_csrs supervisor_trap_csrs_inst (.*);
    core_trap_model core_trap_model_inst (.*);
    ////////////////////////////////////////
    task chk(input logic [63:0] s, input logic [63:0] x);
        compares++;
        if (s !== x) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q, output logic er);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task rd64(input logic [7:0] a, output logic [63:0] q);
        logic [31:0] lo, hi;
        apb(1'b0, a, 32'h0, lo, e);
        apb(1'b0, a + 8'h04, 32'h0, hi, e);
        q = {hi, lo};
    endtask
    task test_done;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // address faults and breakpoints carry the address; illegal carries bits only when enabled
    function automatic logic [63:0] exp_val(logic i, logic [5:0] c, logic [63:0] f, logic [31:0] s,
                                            logic [1:0] l, logic opt);
        if (i) return 64'h0;
        if (c == 6'h02) return !opt ? 64'h0 : l == 2'h1 ? {48'h0, s[15:0]} : l == 2'h2 ? {32'h0, s} : 64'h0;
        if (c < 6'h10 && 16'hB0FB >> c & 16'h1) return f;
        return 64'h0;
    endfunction
    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        test_done;
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, user_mode, counter_read, counter_index} = '0;
        machine_counter_enable = 32'h0;
        pstrb = 4'hF;
        void'($urandom(70505));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        // reset values, then the first unmapped word is refused
        for (int a = 0; a < 44; a += 4) begin
            apb(1'b0, 8'(a), 32'h0, r, e);
            chk(r, 64'h0);
            chk(e, 64'(a == 40));
        end
        // software writes land with only the legal bits kept
        for (int k = 0; k < 27; k++) begin
            d = $urandom;
            apb(1'b1, 8'(4 * (k % 9)), d, r, e);
            apb(1'b0, 8'(4 * (k % 9)), 32'h0, r, e);
            chk(r, d & msk[k % 9]);
        end
        // byte strobes: only the enabled lanes of a write land
        apb(1'b1, 8'h04, 32'h0, r, e);
        pstrb <= 4'h5;
        apb(1'b1, 8'h04, 32'hFFFFFFFF, r, e);
        pstrb <= 4'hF;
        apb(1'b0, 8'h04, 32'h0, r, e);
        chk(r, 64'h00FF00FF);
        // user counter reads need both enable levels
        for (int k = 0; k < 24; k++) begin
            sen = $urandom;
            apb(1'b1, 8'h00, sen, r, e);
            {user_mode, counter_read, counter_index} <= 7'($urandom);
            machine_counter_enable <= k < 4 ? 32'hFFFFFFFF : $urandom;
            @(posedge core_clk);
            #1 chk(counter_illegal, user_mode & counter_read &
                   ~(sen[counter_index] & machine_counter_enable[counter_index]));
        end
        // bit 1 hidden under 32-bit alignment but kept
        apb(1'b1, 8'h24, 32'h1, r, e);
        apb(1'b1, 8'h0C, 32'h6, r, e);
        chk(instruction_alignment, 64'h1);
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk(r, 64'h4);
        apb(1'b1, 8'h24, 32'h0, r, e);
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk(r, 64'h6);
        chk(instruction_alignment, 64'h0);
        // every listed cause code plus three other codes under each alignment and insn-bits setting
        for (int o = 0; o < 4; o++) for (int i = 0; i < 19; i++) begin
            apb(1'b1, 8'h24, 32'(o), r, e);
            pc = {$urandom, $urandom};
            fa = {$urandom, $urandom};
            ins = $urandom;
            ln = 2'($urandom);
            core_trap_model_inst.fire(tab[i][6], tab[i][5:0], pc, fa, ins, ln);
            rd64(8'h0C, v);
            chk(v, {pc[63:2], pc[1] & ~o[0], 1'b0});
            chk(supervisor_return_pc, {pc[63:2], pc[1] & ~o[0], 1'b0});
            rd64(8'h14, v);
            chk(v, {tab[i][6], 57'h0, tab[i][5:0]});
            rd64(8'h1C, v);
            chk(v, exp_val(tab[i][6], tab[i][5:0], fa, ins, ln, o[1]));
        end
        test_done;
    end
endmodule
bind supervisor_trap_csrs trap_csrs_checker trap_csrs_checker_inst (.*);
